// ### gre_pkg.sv
// Purpose: shared constants and carriers of the receive descriptor engine
// Assumes: 32-bit classic Wishbone register bus, 32-bit descriptor DMA port
// Notes: descriptors are 16 bytes, four little-endian words
package gre_pkg;
	// ==========================================================
	// Register map (byte offsets)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RING_LO = 8'h04;
	localparam logic [7:0] REG_RING_HI = 8'h08;
	localparam logic [7:0] REG_INT_STAT = 8'h0C;
	localparam logic [7:0] REG_INT_MASK = 8'h10;
	localparam logic [7:0] REG_RING_POS = 8'h14;
	localparam logic [7:0] REG_KICK = 8'h18;
	localparam int CTRL_EN = 0;
	localparam int CTRL_STRIP = 1;
	localparam int CTRL_SHORT = 2;
	localparam int CTRL_DISC = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam int INT_DONE = 0;
	localparam int INT_NODESC = 1;
	localparam int INT_DROP = 2;
	localparam int INT_ERR = 3;
	localparam int POS_WAIT = 31;
	// ==========================================================
	// Descriptor layout
	localparam logic [63:0] DESC_W1 = 64'h0000_0000_0000_0004;
	localparam logic [63:0] DESC_W2 = 64'h0000_0000_0000_0008;
	localparam logic [63:0] DESC_W3 = 64'h0000_0000_0000_000C;
	localparam int B_OWN = 31;
	localparam int B_EOR = 30;
	localparam int B_FS = 29;
	localparam int B_LS = 28;
	localparam int B_MCAST = 27;
	localparam int B_UCAST = 26;
	localparam int B_BCAST = 25;
	localparam int B_ZERO = 24;
	localparam int B_ONE = 23;
	localparam int B_OVS = 22;
	localparam int B_ERRS = 21;
	localparam int B_RUNT = 20;
	localparam int B_CRC = 19;
	localparam int B_TAG = 16;
	// ==========================================================
	// Frame parsing
	localparam logic [15:0] TPID = 16'h8100;
	localparam logic [15:0] ETYPE_IP = 16'h0800;
	localparam logic [7:0] PROTO_TCP = 8'h06;
	localparam logic [7:0] PROTO_UDP = 8'h11;
	localparam logic [15:0] IDX_TPID = 16'h000C;
	localparam logic [15:0] L3_PLAIN = 16'h000E;
	localparam logic [15:0] L3_TAGGED = 16'h0012;
	localparam logic [15:0] MIN_FRAME = 16'h0040;
	localparam logic [15:0] MAX_FRAME = 16'h2000;
	localparam logic [15:0] CSUM_GOOD = 16'hFFFF;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic crc_err;
		logic align_err;
		logic mcast;
		logic ucast;
		logic bcast;
	} gre_rx_info_s;
	typedef struct packed {
		logic we;
		logic [63:0] addr;
		logic [31:0] wdata;
		logic [3:0] sel;
	} gre_mem_cmd_s;
	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_RD0 = 10'h002,
		S_RD2 = 10'h004,
		S_RD3 = 10'h008,
		S_WAIT_OWN = 10'h010,
		S_RECV = 10'h020,
		S_WRITE = 10'h040,
		S_FLUSH = 10'h080,
		S_WR1 = 10'h100,
		S_WR0 = 10'h200
	} gre_state_e;
endpackage

// ### gre_csum_acc.sv
// Purpose: ones-complement 16-bit sum accumulator
// Assumes: one word per cycle at most
// Notes: clear has priority over add
`timescale 1ns/1ps
`default_nettype none
module gre_csum_acc (
	input wire logic core_clk, // System clock
	input wire logic rst_sync_n, // Synchronised reset, active low
	input wire logic clear, // Restart the sum
	input wire logic add, // Add word this cycle
	input wire logic [15:0] word, // Word to add
	output logic [15:0] sum // Running sum
);
	logic [16:0] wide;
	logic [15:0] next_sum;

	// ==========================================================
	// End-around carry keeps the sum in ones-complement form
	always_comb begin
		wide = {1'b0, sum} + {1'b0, word};
		next_sum = sum;
		if (clear) begin
			next_sum = 16'h0000;
		end else if (add) begin
			next_sum = wide[15:0] + {15'h0000, wide[16]};
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sum <= 16'h0000;
		end else begin
			sum <= next_sum;
		end
	end
endmodule // gre_csum_acc
`default_nettype wire

// ### gre_rx_desc_engine.sv
// Purpose: receive descriptor ring engine, frame store and status writer
// Assumes: MAC stream without FCS, end status valid with rx_eof
// Notes: descriptor and buffer traffic share one word DMA port
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - strip four tag bytes when enabled
// - verify IP, TCP, UDP sums; may discard
// - fill only descriptors with bit 31 set
// - end-of-ring bit wraps pointer to start
// - tag 0x8100 sets bit 16, value 15:0
// - tag holds ID halves, priority, CFI
// - report multicast, unicast match, broadcast class
// - status bit 24 zero, bit 23 one
// - flag frames longer than 8192 bytes
// - error summary on last segment only
// - flag runts; keep them only when allowed
// - flag frame check sequence errors
module gre_rx_desc_engine (
	input wire logic core_clk, // System clock
	input wire logic rst_n, // Reset, active low, async
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Bus write
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte lanes
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Bus acknowledge
	output logic irq, // Level interrupt
	input wire logic rx_valid, // Frame byte valid
	input wire logic [7:0] rx_data, // Frame byte
	input wire logic rx_sof, // First byte of frame
	input wire logic rx_eof, // Last byte of frame
	input wire gre_pkg::gre_rx_info_s rx_info, // End status at rx_eof
	output logic rx_ready, // Byte accepted when high
	output logic mem_req, // DMA request, held to ack
	output gre_pkg::gre_mem_cmd_s mem_cmd, // DMA command
	input wire logic mem_ack, // DMA done
	input wire logic [31:0] mem_rdata // DMA read data
);
	logic rst_meta_n, rst_sync_n;
	logic [3:0] ctrl, next_ctrl, int_stat, next_int_stat, int_mask, next_int_mask;
	logic [63:0] ring_base, next_ring_base;
	logic [31:0] next_dat;
	logic next_ack, next_irq, wb_hit, wb_wr, kick, ring_reset;
	gre_pkg::gre_state_e state, next_state;
	logic [9:0] ring_idx, next_ring_idx;
	logic [13:0] buf_size, next_buf_size, seg_bytes, next_seg_bytes;
	logic [63:0] buf_addr, next_buf_addr, desc_addr;
	logic [31:0] wbuf, next_wbuf, status_w0;
	logic [2:0] wlanes, next_wlanes;
	logic [11:0] word_off, next_word_off;
	logic [7:0] held, next_held, csum_hi, next_csum_hi, proto, next_proto;
	logic [15:0] rx_cnt, next_rx_cnt, tci, next_tci, etype, next_etype;
	logic [15:0] tot, next_tot, held_idx, l3, rel, hlen;
	logic [3:0] ihl, next_ihl;
	logic eor_flag, next_eor_flag, first_pend, next_first_pend, close_last, next_close_last;
	logic held_v, next_held_v, tag_seen, next_tag_seen, eof_seen, next_eof_seen;
	logic is_ip, next_is_ip, udp_nz, next_udp_nz, next_rx_ready, next_mem_req;
	gre_pkg::gre_rx_info_s info, next_info;
	gre_pkg::gre_mem_cmd_s next_cmd;
	logic acc, drop_held, static_drop, full, ip_on, frame_rst, seg_rst;
	logic runt, ovs, errs, csum_bad, drop_cond, ev_done, ev_nodesc, ev_drop, ev_err;
	logic ip_add, l4_add;
	logic [15:0] ip_word, l4_word, ip_sum, l4_sum;
	logic [3:0] sel_mask, ev_vec, w1c;

	// ==========================================================
	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ==========================================================
	// Register bus: one wait state, unmapped reads give zero
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				o[8*i +: 8] = n[8*i +: 8];
			end
		end
		return o;
	endfunction

	always_comb begin
		wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wb_wr = wb_hit && wb_we_i;
		kick = wb_wr && (wb_adr_i == gre_pkg::REG_KICK);
		ring_reset = wb_wr && (wb_adr_i == gre_pkg::REG_RING_LO);
		next_ack = wb_hit;
		next_ctrl = ctrl;
		next_ring_base = ring_base;
		next_int_mask = int_mask;
		w1c = 4'h0;
		if (wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == gre_pkg::REG_CTRL) next_ctrl = wb_dat_i[3:0];
			if (wb_adr_i == gre_pkg::REG_INT_MASK) next_int_mask = wb_dat_i[3:0];
			if (wb_adr_i == gre_pkg::REG_INT_STAT) w1c = wb_dat_i[3:0];
		end
		if (wb_wr && wb_adr_i == gre_pkg::REG_RING_LO) begin
			next_ring_base[31:0] = merge(ring_base[31:0], wb_dat_i, wb_sel_i);
		end
		if (wb_wr && wb_adr_i == gre_pkg::REG_RING_HI) begin
			next_ring_base[63:32] = merge(ring_base[63:32], wb_dat_i, wb_sel_i);
		end
		// A new event wins over a clear in the same cycle
		ev_vec = {ev_err, ev_drop, ev_nodesc, ev_done};
		next_int_stat = (int_stat & ~w1c) | ev_vec;
		next_irq = |(next_int_stat & next_int_mask);
		next_dat = wb_dat_o;
		if (wb_hit && !wb_we_i) begin
			unique case (wb_adr_i)
				gre_pkg::REG_CTRL: next_dat = {28'h0, ctrl};
				gre_pkg::REG_RING_LO: next_dat = ring_base[31:0];
				gre_pkg::REG_RING_HI: next_dat = ring_base[63:32];
				gre_pkg::REG_INT_STAT: next_dat = {28'h0, int_stat};
				gre_pkg::REG_INT_MASK: next_dat = {28'h0, int_mask};
				gre_pkg::REG_RING_POS: next_dat = {(state == gre_pkg::S_WAIT_OWN), 21'h0, ring_idx};
				default: next_dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl <= gre_pkg::CTRL_RST;
			ring_base <= 64'h0;
			int_stat <= 4'h0;
			int_mask <= 4'h0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			ring_base <= next_ring_base;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
			irq <= next_irq;
		end
	end

	// ==========================================================
	// Checksum accumulators: IP header, and L4 with pseudo header
	gre_csum_acc u_ip_sum (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .clear(frame_rst),
		.add(ip_add), .word(ip_word), .sum(ip_sum));
	gre_csum_acc u_l4_sum (.core_clk(core_clk), .rst_sync_n(rst_sync_n), .clear(frame_rst),
		.add(l4_add), .word(l4_word), .sum(l4_sum));

	// ==========================================================
	// Frame status terms, valid once the frame has ended
	always_comb begin
		desc_addr = ring_base + {50'h0, ring_idx, 4'h0};
		held_idx = rx_cnt - 16'h0001;
		static_drop = ctrl[gre_pkg::CTRL_STRIP] && tag_seen && held_idx >= 16'h000D
			&& held_idx <= 16'h000F;
		full = (seg_bytes == buf_size);
		runt = rx_cnt < gre_pkg::MIN_FRAME;
		ovs = rx_cnt > gre_pkg::MAX_FRAME;
		errs = info.crc_err || runt || ovs || info.align_err;
		l3 = tag_seen ? gre_pkg::L3_TAGGED : gre_pkg::L3_PLAIN;
		csum_bad = is_ip && ihl >= 4'h5 && rx_cnt >= l3 + tot && (ip_sum != gre_pkg::CSUM_GOOD
			|| ((proto == gre_pkg::PROTO_TCP || (proto == gre_pkg::PROTO_UDP && udp_nz))
			&& l4_sum != gre_pkg::CSUM_GOOD));
		drop_cond = (csum_bad && ctrl[gre_pkg::CTRL_DISC]) || (runt && !ctrl[gre_pkg::CTRL_SHORT]);
		status_w0 = 32'h0;
		status_w0[gre_pkg::B_EOR] = eor_flag;
		status_w0[gre_pkg::B_FS] = first_pend;
		status_w0[gre_pkg::B_LS] = close_last;
		status_w0[gre_pkg::B_ONE] = 1'b1;
		status_w0[13:0] = seg_bytes;
		if (close_last) begin
			status_w0[gre_pkg::B_MCAST] = info.mcast;
			status_w0[gre_pkg::B_UCAST] = info.ucast;
			status_w0[gre_pkg::B_BCAST] = info.bcast && !info.mcast;
			status_w0[gre_pkg::B_OVS] = ovs;
			status_w0[gre_pkg::B_ERRS] = errs;
			status_w0[gre_pkg::B_RUNT] = runt;
			status_w0[gre_pkg::B_CRC] = info.crc_err;
		end
		unique case (wlanes)
			3'd1: sel_mask = 4'h1;
			3'd2: sel_mask = 4'h3;
			3'd3: sel_mask = 4'h7;
			default: sel_mask = 4'hF;
		endcase
	end

	// ==========================================================
	// Ring walker, byte packer and parser
	always_comb begin
		next_state = state;
		next_ring_idx = ring_idx;
		next_buf_size = buf_size;
		next_buf_addr = buf_addr;
		next_seg_bytes = seg_bytes;
		next_wbuf = wbuf;
		next_wlanes = wlanes;
		next_word_off = word_off;
		next_held = held;
		next_held_v = held_v;
		next_csum_hi = csum_hi;
		next_proto = proto;
		next_rx_cnt = rx_cnt;
		next_tci = tci;
		next_etype = etype;
		next_tot = tot;
		next_ihl = ihl;
		next_eor_flag = eor_flag;
		next_first_pend = first_pend;
		next_close_last = close_last;
		next_tag_seen = tag_seen;
		next_eof_seen = eof_seen;
		next_is_ip = is_ip;
		next_udp_nz = udp_nz;
		next_info = info;
		next_mem_req = mem_req;
		next_cmd = mem_cmd;
		{ev_done, ev_nodesc, ev_drop, ev_err} = 4'h0;
		{frame_rst, seg_rst, ip_add, l4_add} = 4'h0;
		ip_word = 16'h0;
		l4_word = 16'h0;
		acc = (state == gre_pkg::S_RECV) && rx_valid && rx_ready;
		drop_held = ctrl[gre_pkg::CTRL_STRIP] && held_idx == gre_pkg::IDX_TPID
			&& {held, rx_data} == gre_pkg::TPID;
		drop_held = drop_held || static_drop;
		ip_on = (rx_cnt == l3) ? (etype == gre_pkg::ETYPE_IP && rx_data[7:4] == 4'h4) : is_ip;
		hlen = (rx_cnt == l3) ? {10'h0, rx_data[3:0], 2'b00} : {10'h0, ihl, 2'b00};
		rel = rx_cnt - l3;
		unique case (state)
			gre_pkg::S_IDLE: begin
				if (ctrl[gre_pkg::CTRL_EN]) next_state = gre_pkg::S_RD0;
			end
			gre_pkg::S_RD0: begin
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_cmd = '{we: 1'b0, addr: desc_addr, wdata: 32'h0, sel: 4'hF};
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					if (mem_rdata[gre_pkg::B_OWN]) begin
						next_eor_flag = mem_rdata[gre_pkg::B_EOR];
						next_buf_size = mem_rdata[13:0];
						next_state = gre_pkg::S_RD2;
					end else begin
						ev_nodesc = 1'b1;
						next_state = gre_pkg::S_WAIT_OWN;
					end
				end
			end
			gre_pkg::S_RD2, gre_pkg::S_RD3: begin
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_cmd.addr = desc_addr + ((state == gre_pkg::S_RD2) ? gre_pkg::DESC_W2
						: gre_pkg::DESC_W3);
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					if (state == gre_pkg::S_RD2) begin
						next_buf_addr[31:0] = mem_rdata;
						next_state = gre_pkg::S_RD3;
					end else begin
						next_buf_addr[63:32] = mem_rdata;
						next_state = eof_seen ? gre_pkg::S_FLUSH : gre_pkg::S_RECV;
					end
				end
			end
			gre_pkg::S_WAIT_OWN: begin
				if (kick) next_state = gre_pkg::S_RD0;
			end
			gre_pkg::S_RECV: begin
				if (acc && (rx_cnt != 16'h0 || rx_sof)) begin
					if (held_v && !drop_held) begin
						next_wbuf[8*wlanes[1:0] +: 8] = held;
						next_wlanes = wlanes + 3'd1;
						next_seg_bytes = seg_bytes + 14'd1;
					end
					next_held = rx_data;
					next_held_v = 1'b1;
					if (rx_cnt != 16'hFFFF) next_rx_cnt = rx_cnt + 16'h0001;
					if (rx_cnt == gre_pkg::IDX_TPID + 16'h0001) begin
						next_tag_seen = ({held, rx_data} == gre_pkg::TPID);
					end
					if (tag_seen && rx_cnt == 16'h000E) next_tci[15:8] = rx_data;
					if (tag_seen && rx_cnt == 16'h000F) next_tci[7:0] = rx_data;
					if (rx_cnt == l3 - 16'h0002) next_etype[15:8] = rx_data;
					if (rx_cnt == l3 - 16'h0001) next_etype[7:0] = rx_data;
					if (!rx_cnt[0]) next_csum_hi = rx_data;
					if (rx_cnt == l3) begin
						next_is_ip = ip_on;
						next_ihl = rx_data[3:0];
					end
					if (ip_on && rx_cnt >= l3) begin
						if (rel < hlen) begin
							ip_add = rx_cnt[0] || rx_eof;
							ip_word = rx_cnt[0] ? {csum_hi, rx_data} : {rx_data, 8'h00};
							if (rel >= 16'h000C && rel <= 16'h0013) begin
								l4_add = ip_add;
								l4_word = ip_word;
							end
							if (rel == 16'h0009) begin
								next_proto = rx_data;
								l4_add = 1'b1;
								l4_word = {8'h00, rx_data};
							end
							if (rel == 16'h0002) next_tot[15:8] = rx_data;
							if (rel == 16'h0003) next_tot[7:0] = rx_data;
						end else if (rel < tot) begin
							l4_add = rx_cnt[0] || rx_eof || rel == hlen;
							l4_word = rx_cnt[0] ? {csum_hi, rx_data} : {rx_data, 8'h00};
							if (rel == hlen && !rx_eof) l4_word = tot - hlen;
							if ((rel == hlen + 16'h0006 || rel == hlen + 16'h0007) && rx_data != 8'h00) begin
								next_udp_nz = 1'b1;
							end
						end
					end
					if (rx_eof) begin
						next_eof_seen = 1'b1;
						next_info = rx_info;
					end
				end
				if (next_wlanes == 3'd4) next_state = gre_pkg::S_WRITE;
				else if (next_eof_seen) next_state = gre_pkg::S_FLUSH;
				else if (!acc && full && held_v && !static_drop) begin
					next_close_last = 1'b0;
					next_state = gre_pkg::S_WR0;
				end
			end
			gre_pkg::S_WRITE: begin
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_cmd = '{we: 1'b1, addr: buf_addr + {50'h0, word_off, 2'b00},
						wdata: wbuf, sel: sel_mask};
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_word_off = word_off + 12'd1;
					next_wlanes = 3'd0;
					next_wbuf = 32'h0;
					next_state = eof_seen ? gre_pkg::S_FLUSH : gre_pkg::S_RECV;
				end
			end
			gre_pkg::S_FLUSH: begin
				if (held_v && static_drop) begin
					next_held_v = 1'b0;
				end else if (held_v && full) begin
					next_close_last = 1'b0;
					next_state = gre_pkg::S_WR0;
				end else if (held_v) begin
					next_wbuf[8*wlanes[1:0] +: 8] = held;
					next_wlanes = wlanes + 3'd1;
					next_seg_bytes = seg_bytes + 14'd1;
					next_held_v = 1'b0;
					if (next_wlanes == 3'd4) next_state = gre_pkg::S_WRITE;
				end else if (wlanes != 3'd0) begin
					next_state = gre_pkg::S_WRITE;
				end else if (first_pend && drop_cond) begin
					ev_drop = 1'b1;
					frame_rst = 1'b1;
					seg_rst = 1'b1;
					next_state = gre_pkg::S_RECV;
				end else begin
					next_state = gre_pkg::S_WR1;
				end
			end
			gre_pkg::S_WR1: begin
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_cmd = '{we: 1'b1, addr: desc_addr + gre_pkg::DESC_W1,
						wdata: {15'h0, tag_seen, tci}, sel: 4'hF};
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_close_last = 1'b1;
					next_state = gre_pkg::S_WR0;
				end
			end
			gre_pkg::S_WR0: begin
				if (!mem_req) begin
					next_mem_req = 1'b1;
					next_cmd = '{we: 1'b1, addr: desc_addr, wdata: status_w0, sel: 4'hF};
				end else if (mem_ack) begin
					next_mem_req = 1'b0;
					next_ring_idx = eor_flag ? 10'h000 : ring_idx + 10'h001;
					seg_rst = 1'b1;
					next_first_pend = 1'b0;
					next_state = gre_pkg::S_RD0;
					if (close_last) begin
						ev_done = 1'b1;
						ev_err = errs || csum_bad;
						frame_rst = 1'b1;
						if (!ctrl[gre_pkg::CTRL_EN]) next_state = gre_pkg::S_IDLE;
					end
				end
			end
			default: next_state = gre_pkg::S_IDLE;
		endcase
		if (seg_rst) begin
			next_seg_bytes = 14'h0;
			next_word_off = 12'h0;
		end
		if (frame_rst) begin
			{next_rx_cnt, next_tci, next_etype, next_tot} = 64'h0;
			{next_held_v, next_tag_seen, next_eof_seen, next_is_ip, next_udp_nz} = 5'h0;
			next_first_pend = 1'b1;
			next_proto = 8'h00;
			next_ihl = 4'h0;
		end
		if (ring_reset) next_ring_idx = 10'h000;
		next_rx_ready = (next_state == gre_pkg::S_RECV) && !(next_seg_bytes == next_buf_size
			&& next_held_v);
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= gre_pkg::S_IDLE;
			{ring_idx, buf_size, seg_bytes, word_off} <= 50'h0;
			{buf_addr, wbuf, wlanes} <= 99'h0;
			{held, csum_hi, proto, ihl} <= 28'h0;
			{rx_cnt, tci, etype, tot} <= 64'h0;
			{eor_flag, close_last, held_v, tag_seen, eof_seen, is_ip, udp_nz} <= 7'h0;
			first_pend <= 1'b1;
			info <= '0;
			rx_ready <= 1'b0;
			mem_req <= 1'b0;
			mem_cmd <= '0;
		end else begin
			state <= next_state;
			{ring_idx, buf_size, seg_bytes, word_off} <= {next_ring_idx, next_buf_size,
				next_seg_bytes, next_word_off};
			{buf_addr, wbuf, wlanes} <= {next_buf_addr, next_wbuf, next_wlanes};
			{held, csum_hi, proto, ihl} <= {next_held, next_csum_hi, next_proto, next_ihl};
			{rx_cnt, tci, etype, tot} <= {next_rx_cnt, next_tci, next_etype, next_tot};
			{eor_flag, close_last, held_v, tag_seen} <= {next_eor_flag, next_close_last,
				next_held_v, next_tag_seen};
			{eof_seen, is_ip, udp_nz} <= {next_eof_seen, next_is_ip, next_udp_nz};
			first_pend <= next_first_pend;
			info <= next_info;
			rx_ready <= next_rx_ready;
			mem_req <= next_mem_req;
			mem_cmd <= next_cmd;
		end
	end
endmodule // gre_rx_desc_engine
`default_nettype wire

// ### gre_rx_desc_engine_assertions.sv
// Purpose: port checks of the receive descriptor engine
// Assumes: bound to the top module
// Notes: frame contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module gre_rx_desc_engine_assertions (
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [7:0] wb_adr_i, // Address
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire logic rx_valid, // Byte valid
	input wire logic rx_ready, // Byte ready
	input wire logic mem_req, // DMA request
	input wire gre_pkg::gre_mem_cmd_s mem_cmd, // DMA command
	input wire logic mem_ack // DMA done
);
	// ==========
	// Handshakes
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("bus ack held");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus ack without request");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h18 |-> wb_dat_o == 0)
		else $error("unmapped read not zero");
	a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
		else $error("DMA request dropped early");
	a_req_gap: assert property (mem_ack |=> !mem_req) else $error("DMA request without gap");
	a_word_aligned: assert property (mem_req |-> mem_cmd.addr[1:0] == 2'h0)
		else $error("DMA address not word aligned");
	a_lanes_legal: assert property (mem_req && mem_cmd.we |-> mem_cmd.sel inside {4'h1, 4'h3, 4'h7, 4'hF})
		else $error("DMA lanes illegal");
	c_byte: cover property (rx_valid && rx_ready);
	c_write: cover property (mem_ack && mem_cmd.we);
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // gre_rx_desc_engine_assertions
bind gre_rx_desc_engine gre_rx_desc_engine_assertions chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack));
`default_nettype wire

// ### gre_mem_model.sv
// Purpose: host memory behind the DMA port
// Assumes: addresses below 0x400
// Notes: slow mode answers after four cycles
`timescale 1ns/1ps
`default_nettype none
module gre_mem_model (
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic slow, // Late answers
	input wire logic mem_req, // Request
	input wire gre_pkg::gre_mem_cmd_s mem_cmd, // Command
	output logic mem_ack, // Done pulse
	output logic [31:0] mem_rdata // Read data
);
	logic [31:0] mem [0:255];
	logic [1:0] wait_cnt;
	int k;
	// ==========
	// Answer
	// Idle read data flips each cycle so a stale sample never passes
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			mem_rdata <= 32'h0;
		end else if (mem_req && !mem_ack && wait_cnt != {slow, slow}) begin
			wait_cnt <= wait_cnt + 2'h1;
		end else if (mem_req && !mem_ack) begin
			mem_ack <= 1'b1;
			wait_cnt <= 2'h0;
			mem_rdata <= mem[mem_cmd.addr[9:2]];
			for (k = 0; k < 4; k++)
				if (mem_cmd.we && mem_cmd.sel[k]) mem[mem_cmd.addr[9:2]][8*k+:8] <= mem_cmd.wdata[8*k+:8];
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // gre_mem_model
`default_nettype wire

// ### tb_gige_rx_descriptor_engine.sv
// Purpose: self-checking bench of the receive descriptor engine
// Assumes: ring at 0x000, buffers at 0x100 and 0x200
// Notes: status writes and reads meet a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_gige_rx_descriptor_engine;
	logic core_clk = 0, rst_n = 0, slow = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic rx_valid = 0, rx_sof = 0, rx_eof = 0, wb_ack_o, irq, rx_ready, mem_req, mem_ack;
	logic [7:0] wb_adr_i = 0, rx_data = 0, fr[$];
	logic [31:0] wb_dat_i = 0, wb_dat_o, mem_rdata, exp_q[$], msk_q[$];
	logic [15:0] tag;
	gre_pkg::gre_rx_info_s rx_info = '0;
	gre_pkg::gre_mem_cmd_s mem_cmd;
	int failures = 0, cmp_count = 0, cycles = 0, seed = 8371, i;
	gre_rx_desc_engine uut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(4'hF), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_sof(rx_sof), .rx_eof(rx_eof),
		.rx_info(rx_info), .rx_ready(rx_ready), .mem_req(mem_req), .mem_cmd(mem_cmd),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	gre_mem_model mem_i (.core_clk(core_clk), .rst_n(rst_n), .slow(slow), .mem_req(mem_req),
		.mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// ==========
	// Tasks
	always #20 core_clk = ~core_clk;
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	task push(input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
	endtask
	// No note pending counts as a mismatch
	task pop_chk(input logic [31:0] g);
		logic [31:0] m;
		if (exp_q.size() == 0) chk(1, 0);
		m = msk_q.pop_front();
		chk(g & m, exp_q.pop_front() & m);
	endtask
	// Sample at the falling edge, where registered outputs have settled
	task wait_on(input bit rdy);
		logic g;
		do begin
			@(negedge core_clk);
			g = rdy ? rx_ready : wb_ack_o;
			@(posedge core_clk);
		end while (g !== 1'b1);
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, e, m);
		if (!w) push(e, m);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wait_on(0);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge core_clk);
	endtask
	task mk(input logic [7:0] d0, input bit tg, input int n);
		fr = {d0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		if (tg) fr = {fr, 8'h81, 8'h00, tag[15:8], tag[7:0]};
		fr = {fr, 8'h88, 8'hB5};
		while (fr.size() < n) fr.push_back(8'($random(seed)));
	endtask
	task send(input gre_pkg::gre_rx_info_s inf);
		for (i = 0; i < fr.size(); i++) begin
			rx_valid <= 1;
			rx_data <= fr[i];
			rx_sof <= (i == 0);
			rx_eof <= (i == fr.size() - 1);
			rx_info <= inf;
			wait_on(1);
		end
		rx_valid <= 0;
		while (exp_q.size() != 0) @(posedge core_clk);
	endtask
	// ==========
	// Monitor: descriptor words 0 and 1 written back, and register reads
	always @(negedge core_clk) begin
		if (wb_ack_o === 1'b1 && !wb_we_i) pop_chk(wb_dat_o);
		if (mem_ack && mem_cmd.we && mem_cmd.addr < 64'h20 && !mem_cmd.addr[3])
			pop_chk(mem_cmd.wdata);
	end
	// Hang guard well above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("ERROR %0t timeout", $time);
			end_of_test();
		end
	end
	// ==========
	// Scenarios
	initial begin
		mem_i.mem[0] = 32'h8000_00F8;
		mem_i.mem[2] = 32'h100;
		mem_i.mem[3] = 0;
		mem_i.mem[4] = 32'hC000_00F8;
		mem_i.mem[6] = 32'h200;
		mem_i.mem[7] = 0;
		tag = 16'($random(seed));
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		repeat (3) @(posedge core_clk);
		bus(1, gre_pkg::REG_RING_LO, 0, 0, 0);
		bus(1, gre_pkg::REG_RING_HI, 0, 0, 0);
		bus(1, gre_pkg::REG_INT_MASK, 1, 0, 0);
		bus(1, gre_pkg::REG_CTRL, 7, 0, 0);
		bus(0, gre_pkg::REG_CTRL, 0, 7, 32'hF);
		bus(0, 8'h1C, 0, 0, 32'hFFFF_FFFF);
		$display("register test done");
		mk(8'hFF, 1, 72);
		push({16'h0001, tag}, 32'h0001_FFFF);
		push(32'h3280_0044, 32'hFFF8_3FFF);
		send(5'h01);
		chk(mem_i.mem[67], {fr[19], fr[18], 8'hB5, 8'h88});
		$display("tagged frame test done");
		slow <= 1;
		mk(8'h01, 0, 41);
		push(0, 32'h0001_0000);
		push(32'h78B8_0029, 32'hFFF8_3FFF);
		send(5'h14);
		repeat (16) @(posedge core_clk);
		bus(0, gre_pkg::REG_RING_POS, 0, 32'h8000_0000, 32'h8000_03FF);
		bus(0, gre_pkg::REG_INT_STAT, 0, 9, 9);
		chk({31'h0, irq}, 1);
		bus(1, gre_pkg::REG_INT_STAT, 32'hF, 0, 0);
		bus(0, gre_pkg::REG_INT_STAT, 0, 0, 9);
		chk({31'h0, irq}, 0);
		$display("runt frame and interrupt test done");
		end_of_test();
	end
endmodule // tb_gige_rx_descriptor_engine
`default_nettype wire
